//--- verilog/vidcs_top.sv
/*
 * Processor-side platform control: voltage code, bus clock select, thermal trip,
 * open-drain status outputs, breakpoint monitor pins and asynchronous inputs.
 * Assumes ref_clk is the bus clock phase zero reference, the mask, ignore and breakpoint
 * monitor input pins are asynchronous to it and the other inputs are common-clock.
 */

// Overview of operation
// [R1] A six-bit voltage code is driven on push-pull outputs, one meaning high.
// [R2] Code zero means supply off, code one is the highest voltage, all ones the lowest.
// [R3] The regulator supplies exactly the voltage the current code selects.
// [R4] Once thermal trip asserts, all internal activity stops.
// [R5] The platform removes core power within 500 ms of a trip or external overtemperature.
// [R6] A three-bit bus clock select code is driven; only the 166 MHz pattern is used.
// [R7] Common-clock signals are sampled and driven on the rising bus clock edge.
// [R8] Source-synchronous groups are timed to their own strobes, not handled here.
// [R9] Asynchronous inputs may change anywhere in a clock cycle and are synchronised.
// [R10] Each asynchronous input must stay asserted three clocks to be recognised; breakpoint monitor inputs are only synchronised, not qualified.
// [R11] Error, trip and overheat outputs are open drain with no clock timing relation.
// [R12] Breakpoint monitor bits 2 and 1 and probe ready are outputs only.
// [R13] The voltage code stays within the supported range and never shows supply off.
`timescale 1ns/10ps
`default_nettype none
`include "vidcs_regs.svh"

module vidcs_top #(
	parameter logic [5:0] VID_BOOT = `VIDCS_VID_BOOT,
	parameter logic [5:0] VID_LOW_LIMIT = `VIDCS_VID_MIN_V,
	parameter logic [5:0] VID_HIGH_LIMIT = `VIDCS_VID_MAX_V
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [5:0] target_vid,
	input wire logic target_load,
	input wire logic die_overtemp,
	input wire logic die_hot,
	input wire logic fp_error,
	input wire logic core_error,
	input wire logic addr20_mask_n,
	input wire logic ignore_numeric_error_n,
	input wire logic [3:0] breakpoint_monitor_n_in,
	input wire logic [3:0] bpm_drive,
	input wire logic probe_ready,
	output logic [5:0] voltage_id_code,
	output logic [2:0] bus_clock_select,
	output logic vid_busy,
	output logic addr20_mask,
	output logic ignore_numeric_error,
	output logic [3:0] bpm_seen,
	output logic thermal_trip_n_out,
	output logic thermal_trip_n_oe,
	output logic overheat_n_out,
	output logic overheat_n_oe,
	output logic float_error_n_out,
	output logic float_error_n_oe,
	output logic internal_error_n_out,
	output logic internal_error_n_oe,
	output logic [3:0] breakpoint_monitor_n_out,
	output logic [3:0] breakpoint_monitor_n_oe,
	output logic probe_ready_n_out,
	output logic probe_ready_n_oe
);
	vidcs_pkg::vidcs_state_type state;
	logic [5:0] goal;
	logic [5:0] next_vid;
	logic tripped;
	logic run_en;
	logic fp_err_q;
	logic core_err_q;
	logic hot_q;
	logic probe_ready_n_q;
	logic [3:0] bpm_drv_q;
	logic [3:0] bpm_meta;
	logic [3:0] bpm_sync;

	// Clamp to the supported window; zero would command the supply off.
	function automatic logic [5:0] clamp_vid(input logic [5:0] code);
		logic [5:0] c;
		c = code;
		if (c < VID_HIGH_LIMIT || c == `VIDCS_VID_OFF)
			c = VID_HIGH_LIMIT;
		if (c > VID_LOW_LIMIT)
			c = VID_LOW_LIMIT;
		return c; // [R13]
	endfunction

	// One code toward the goal; a ramp never skips a code on its way.
	function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] dest);
		logic [5:0] n;
		n = cur;
		if (cur < dest)
			n = cur + 6'h01;
		else if (cur > dest)
			n = cur - 6'h01;
		return n; // [R2]
	endfunction

	// A trip freezes everything except the trip latch itself.
	assign run_en = clk_en && !tripped; // [R4]

	vidcs_async_in a20_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(run_en),
		.pin_n(addr20_mask_n),
		.active(addr20_mask)
	); // [R9]

	vidcs_async_in ign_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(run_en),
		.pin_n(ignore_numeric_error_n),
		.active(ignore_numeric_error)
	); // [R9]

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tripped <= 1'b0;
		end else if (clk_en && die_overtemp) begin
			tripped <= 1'b1; // [R4]
		end
	end

	// Voltage moves one code per clock so the regulator sees a smooth ramp.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= vidcs_pkg::VIDCS_RUN;
		end else if (run_en) begin
			unique case (state)
				vidcs_pkg::VIDCS_RUN: begin
					if (target_load)
						state <= vidcs_pkg::VIDCS_STEP;
				end
				vidcs_pkg::VIDCS_STEP: begin
					if (voltage_id_code == goal)
						state <= vidcs_pkg::VIDCS_RUN;
				end
				default: begin
					state <= vidcs_pkg::VIDCS_RUN;
				end
			endcase
		end
	end

	// Requests are taken only while idle; a load during a ramp is ignored.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			goal <= VID_BOOT;
		end else if (run_en && state == vidcs_pkg::VIDCS_RUN && target_load) begin
			goal <= clamp_vid(target_vid); // [R13]
		end
	end

	always_comb begin
		next_vid = step_toward(voltage_id_code, goal);
	end

	// The code register alone drives the regulator pins, so they never glitch.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			voltage_id_code <= VID_BOOT; // [R1]
		end else if (run_en && state == vidcs_pkg::VIDCS_STEP) begin
			voltage_id_code <= next_vid; // [R2]
		end
	end

	assign vid_busy = (state != vidcs_pkg::VIDCS_RUN);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_clock_select <= `VIDCS_BSEL_166;
		end else if (run_en) begin
			bus_clock_select <= `VIDCS_BSEL_166; // [R6]
		end
	end

	// Status outputs are registered; only their pull-down timing matters outside.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fp_err_q <= 1'b0;
			core_err_q <= 1'b0;
			hot_q <= 1'b0;
			probe_ready_n_q <= 1'b0;
			bpm_drv_q <= 4'h0;
		end else if (run_en) begin
			fp_err_q <= fp_error;
			core_err_q <= core_error;
			hot_q <= die_hot;
			probe_ready_n_q <= probe_ready;
			bpm_drv_q <= bpm_drive;
		end
	end

	// Open drain: the low level is driven, the high level comes from the pull-up.
	assign thermal_trip_n_out = 1'b0; // [R11]
	assign thermal_trip_n_oe = tripped; // [R11]
	assign overheat_n_out = 1'b0; // [R11]
	assign overheat_n_oe = hot_q || tripped; // [R11]
	assign float_error_n_out = 1'b0; // [R11]
	assign float_error_n_oe = fp_err_q; // [R11]
	assign internal_error_n_out = 1'b0; // [R11]
	assign internal_error_n_oe = core_err_q; // [R11]

	// Bits 2 and 1 are always driven; bits 3 and 0 drive only when asked.
	assign breakpoint_monitor_n_out = ~bpm_drv_q; // [R7]
	assign breakpoint_monitor_n_oe = bpm_drv_q | `VIDCS_BPM_OUT_ONLY; // [R12]
	assign probe_ready_n_out = ~probe_ready_n_q; // [R12]
	assign probe_ready_n_oe = 1'b1; // [R12]

	// Returned breakpoint levels are treated as outside the clock domain.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bpm_meta <= 4'hf;
			bpm_sync <= 4'hf;
			bpm_seen <= 4'h0;
		end else if (run_en) begin
			bpm_meta <= breakpoint_monitor_n_in;
			bpm_sync <= bpm_meta;
			bpm_seen <= ~bpm_sync & ~`VIDCS_BPM_OUT_ONLY; // [R12]
		end
	end
endmodule

`default_nettype wire

//--- verilog/vidcs_regs.svh
/*
 * Constants for the voltage code and clock select block: codes, widths, timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VIDCS_REGS_SVH
`define VIDCS_REGS_SVH

`define VIDCS_VID_WIDTH 6
`define VIDCS_VID_OFF 6'h00
`define VIDCS_VID_MAX_V 6'h01
`define VIDCS_VID_MIN_V 6'h3f
`define VIDCS_VID_BOOT 6'h29
`define VIDCS_BSEL_WIDTH 3
`define VIDCS_BSEL_166 3'h3
`define VIDCS_BSEL_RSV0 3'h0
`define VIDCS_BSEL_RSV1 3'h1
`define VIDCS_BSEL_RSV2 3'h2
`define VIDCS_MIN_ASSERT_CLKS 3
`define VIDCS_BPM_WIDTH 4
`define VIDCS_BPM_OUT_ONLY 4'h6

`endif

//--- verilog/vidcs_pkg.sv
/*
 * Types for the voltage code and clock select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vidcs_pkg;
	typedef enum logic [1:0] {
		VIDCS_RUN = 2'b00,
		VIDCS_STEP = 2'b01,
		VIDCS_TRIPPED = 2'b10
	} vidcs_state_type;
endpackage

//--- verilog/vidcs_async_in.sv
/*
 * Synchroniser and three-clock qualifier for one asynchronous active-low input.
 * Assumes the input may change anywhere within a clock cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vidcs_regs.svh"

module vidcs_async_in (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic pin_n,
	output logic active
);
	logic meta_n;
	logic sync_n;
	logic [1:0] run;

	// Two flip-flops before any logic looks at the pin.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_n <= 1'b1;
			sync_n <= 1'b1;
		end else if (clk_en) begin
			meta_n <= pin_n;
			sync_n <= meta_n;
		end
	end

	// Pulses shorter than three clocks are not recognised.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run <= 2'h0;
			active <= 1'b0;
		end else if (clk_en) begin
			if (sync_n) begin
				run <= 2'h0;
				active <= 1'b0;
			end else if (run == 2'(`VIDCS_MIN_ASSERT_CLKS - 1)) begin
				active <= 1'b1; // [R10]
			end else begin
				run <= run + 2'h1;
			end
		end
	end
endmodule

`default_nettype wire

//--- tb/vidcs_vreg.sv
/*
 * Regulator and clock generator model facing the voltage code pins.
 * Assumes the trip wire has a pull-up and the clock is the bus clock.
 */
`timescale 1ns/10ps
`default_nettype none
module vidcs_vreg #(
	parameter int OFF_CLKS = 40
) (
	input wire logic ref_clk,
	input wire logic [5:0] code,
	input wire logic [2:0] bsel,
	input wire logic trip_n,
	output int supply,
	output int bclk_mhz,
	output logic power_on
);
	int cnt = 0;
	// The power-off wait is a shortened stand-in for the long platform limit.
	always_ff @(posedge ref_clk) begin
		if (!trip_n) cnt <= cnt + 1;
	end
	assign power_on = cnt < OFF_CLKS;
	// Supply in tenths of a millivolt.
	assign supply = (power_on && code != 6'h00) ? 16000 - (code - 1) * 125 : 0;
	assign bclk_mhz = (bsel == 3'h3) ? 166 : 0;
endmodule
`default_nettype wire

//--- tb/vidcs_top_monitor.sv
/*
 * Concurrent checks on the ports of the voltage code block.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
`default_nettype none
module vidcs_top_monitor (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic die_overtemp,
	input wire logic addr20_mask_n,
	input wire logic [5:0] voltage_id_code,
	input wire logic [2:0] bus_clock_select,
	input wire logic vid_busy,
	input wire logic addr20_mask,
	input wire logic [3:0] bpm_seen,
	input wire logic thermal_trip_n_out,
	input wire logic thermal_trip_n_oe,
	input wire logic overheat_n_out,
	input wire logic overheat_n_oe,
	input wire logic float_error_n_out,
	input wire logic internal_error_n_out,
	input wire logic [3:0] breakpoint_monitor_n_oe,
	input wire logic probe_ready_n_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	bsel_fixed_a: assert property (bus_clock_select == 3'h3) else $error("bsel moved");
	vid_on_a: assert property (voltage_id_code != 6'h00) else $error("vid off");
	vid_step_a: assert property ($changed(voltage_id_code) |->
		voltage_id_code == $past(voltage_id_code) + 6'h01 ||
		voltage_id_code == $past(voltage_id_code) - 6'h01) else $error("vid jump");
	trip_hold_a: assert property (thermal_trip_n_oe |=> thermal_trip_n_oe) else $error("trip");
	trip_freeze_a: assert property (thermal_trip_n_oe |=> $stable(voltage_id_code))
		else $error("vid moved after trip");
	trip_cause_a: assert property (clk_en && die_overtemp |=> thermal_trip_n_oe && overheat_n_oe)
		else $error("trip late");
	od_low_a: assert property (!(thermal_trip_n_out | overheat_n_out | float_error_n_out
		| internal_error_n_out)) else $error("open drain high");
	out_only_a: assert property (&breakpoint_monitor_n_oe[2:1] && probe_ready_n_oe
		&& bpm_seen[2:1] == 2'h0) else $error("out only pin");
	async_min_a: assert property ($rose(addr20_mask) |-> !$past(addr20_mask_n, 4)
		&& !$past(addr20_mask_n, 5)) else $error("mask early");
	cover property ($rose(thermal_trip_n_oe));
	cover property ($rose(addr20_mask));
	cover property ($fell(vid_busy));
endmodule
bind vidcs_top vidcs_top_monitor vidcs_top_monitor_i (.*);
`default_nettype wire

//--- tb/test_voltage_id_clock_select.sv
/*
 * Self-checking bench for the voltage code block with a regulator model.
 * Assumes the design files and the monitor are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module test_voltage_id_clock_select;
	logic ref_clk = 0, rst = 1, load = 0, ot = 0, hot = 0, fpe = 0, ce = 0, pa = 0, a = 1;
	logic en = 1;
	logic [2:0] bsel;
	logic [3:0] seen;
	logic [5:0] tv = 6'h00;
	logic [3:0] bd = 4'h0, bpo, bpe;
	logic [5:0] vid;
	logic busy, tro, tre, m20, ign, hoe, foe, ioe, pro;
	logic [15:0] r = 16'hbb1a;
	wire logic trip_n = tre ? tro : 1'b1;
	int supply, mhz, fails = 0, compares = 0, cyc = 0, e;
	logic pon;
	always #4 ref_clk = ~ref_clk;
	vidcs_top vidcs_top_i (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .target_vid(tv),
		.target_load(load), .die_overtemp(ot), .die_hot(hot), .fp_error(fpe), .core_error(ce),
		.addr20_mask_n(a), .ignore_numeric_error_n(a),
		.breakpoint_monitor_n_in(bpo | ~bpe), .bpm_drive(bd), .probe_ready(pa),
		.voltage_id_code(vid), .bus_clock_select(bsel), .vid_busy(busy), .addr20_mask(m20),
		.ignore_numeric_error(ign), .bpm_seen(seen), .thermal_trip_n_out(tro),
		.thermal_trip_n_oe(tre), .overheat_n_out(), .overheat_n_oe(hoe),
		.float_error_n_out(), .float_error_n_oe(foe), .internal_error_n_out(),
		.internal_error_n_oe(ioe), .breakpoint_monitor_n_out(bpo),
		.breakpoint_monitor_n_oe(bpe), .probe_ready_n_out(pro), .probe_ready_n_oe());
	vidcs_vreg #(.OFF_CLKS(40)) vidcs_vreg_i (.ref_clk(ref_clk), .code(vid),
		.bsel(bsel), .trip_n(trip_n), .supply(supply),
		.bclk_mhz(mhz), .power_on(pon));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (s !== x) begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", n, x, s);
		end
	endtask
	task automatic final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic ramp(input logic [5:0] t);
		tv = t;
		load = 1;
		@(negedge ref_clk) load = 0;
		for (int i = 0; i < 100 && (i < 2 || busy !== 1'b0); i++) @(negedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 0;
		chk("reset vid", 6'h29, vid);
		chk("clock mhz", 166, mhz);
		for (int k = 0; k < 10; k++) begin
			r = nx(r);
			ramp(k == 0 ? 6'h00 : k == 1 ? 6'h3f : r[5:0]);
			e = (tv == 6'h00) ? 1 : tv;
			chk("vid", e, vid);
			chk("supply", 16000 - (e - 1) * 125, supply);
		end
		$display("test ramp done");
		for (int w = 2; w < 10; w += (w == 2) ? 1 : 5) begin
			a = 0;
			for (int c = 1; c <= 12; c++) begin
				@(negedge ref_clk);
				if (c == w)
					a = 1;
				if (c == 5) begin
					chk("mask", w > 2, m20);
					chk("ignore", w > 2, ign);
				end
			end
			chk("mask released", 0, m20);
		end
		chk("mask idle", 0, m20);
		$display("test async done");
		repeat (8) begin
			r = nx(r);
			{hot, fpe, ce, pa} = r[3:0];
			bd = r[7:4];
			@(negedge ref_clk);
			chk("float oe", fpe, foe);
			chk("int oe", ce, ioe);
			chk("hot oe", hot, hoe);
			chk("bpm oe", bd | 4'h6, bpe);
			chk("probe", !pa, pro);
		end
		bd = 4'hf;
		repeat (5) @(negedge ref_clk);
		chk("bpm seen", 4'h9, seen);
		$display("test status done");
		e = vid;
		en = 0;
		tv = (vid == 6'h01) ? 6'h3f : 6'h01;
		load = 1;
		fpe = !foe;
		repeat (3) @(negedge ref_clk);
		chk("held vid", e, vid);
		chk("held busy", 0, busy);
		chk("held float", !fpe, foe);
		load = 0;
		en = 1;
		@(negedge ref_clk);
		$display("test enable done");
		e = vid;
		ot = 1;
		@(negedge ref_clk) ot = 0;
		chk("trip", 1, tre);
		chk("trip overheat", 1, hoe);
		ramp(6'h10);
		chk("frozen vid", e, vid);
		repeat (45) @(negedge ref_clk);
		chk("power off", 0, supply);
		$display("test trip done");
		rst = 1;
		repeat (2) @(negedge ref_clk);
		rst = 0;
		chk("trip cleared", 0, tre);
		chk("reset vid again", 6'h29, vid);
		ramp(6'h2b);
		chk("vid after reset", 6'h2b, vid);
		$display("test reset done");
		final_report;
	end
endmodule
`default_nettype wire
